// >>> core/prc_defs.svh
/*
 * Constants of the parallel readout port: command word layout, register
 * addresses and reset values, channel codes, self-test codes, pin indices.
 * Assumes it is included by bare name from the port module and the bench.
 */
// Function
// - mode pins 00 at release: software mode
// - interface pin low at release: parallel port
// - trigger rise starts conversion, busy until done
// - drive data only while select, read low
// - chip select rise floats bus, fall releases
// - two reads for A and B, more with status
// - first read gives A, next gives B
// - register access only in software mode
// - write strobe rise latches one command word
// - read command loads output register, next read
// - self-test channel forces fixed A, B codes
// - self-test selectable only in software mode
// - no CRC on hardware parallel port
// - CRC lives in status; CRC, status coupled
// - hardware CRC pin latched at reset release
// - either config bit turns CRC on
// - CRC starts zero, A then B
// - CRC bits are fixed XOR equations
// - status word read after conversion results
// - channel register selects supply, regulator nodes
// - hardware mode: pins configure, data only
// - reset selects first A and B inputs
`ifndef PRC_DEFS_SVH
`define PRC_DEFS_SVH

`define PRC_FIFO_DEPTH       16
`define PRC_WORD_W           16
`define PRC_CMD_WRITE_BIT    15
`define PRC_CMD_ADDR_MSB     14
`define PRC_CMD_ADDR_LSB     9
`define PRC_CMD_DATA_MSB     8
`define PRC_ADDR_CONFIG      6'h02
`define PRC_ADDR_CHANNEL     6'h03
`define PRC_ADDR_STATUS      6'h04
`define PRC_CFG_CRC_BIT      0
`define PRC_CFG_STATUS_BIT   1
`define PRC_CFG_RESET        9'h000
`define PRC_CHAN_RESET       9'h000
`define PRC_CH_SUPPLY        4'h8
`define PRC_CH_REGULATOR     4'h9
`define PRC_CH_SELFTEST      4'hB
`define PRC_SELFTEST_A       16'hAAAA
`define PRC_SELFTEST_B       16'h5555
`define PRC_CRC_INIT         8'h00
`define PRC_MODE_SOFTWARE    2'h0
`define PRC_IF_PARALLEL      1'b0
`define PRC_SETTLE_CYCLES    2'h2
`define PRC_SYNC_W           24
`define PRC_SYNC_RESET       24'h700000
`define PRC_PIN_TRIG         23
`define PRC_PIN_CS           22
`define PRC_PIN_RD           21
`define PRC_PIN_WR           20
`define PRC_PIN_MODE_MSB     19
`define PRC_PIN_MODE_LSB     18
`define PRC_PIN_IF           17
`define PRC_PIN_CRC          16

`endif

// >>> core/prc_pkg.sv
/*
 * Types of the parallel readout port: operating mode and conversion states.
 * Assumes nothing of its surroundings.
 */
package prc_pkg;

  typedef enum logic {
    MODE_SOFTWARE,
    MODE_HARDWARE
  } op_mode_t;

  typedef enum logic [2:0] {
    CONV_IDLE,
    CONV_WAIT,
    CONV_PUSH_A,
    CONV_PUSH_B,
    CONV_PUSH_STATUS
  } conv_state_t;

endpackage

// >>> core/sync_word_fifo.sv
/*
 * Single-clock word FIFO with registered head word and synchronous flush.
 * Assumes DEPTH is a power of two and both sides run on clk_sys.
 */
`timescale 1ns/1ps
module sync_word_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input  logic             clk_sys,
  input  logic             rst_n,
  input  logic             clk_en,
  input  logic             flush,
  input  logic             wr_valid,
  output logic             wr_ready,
  input  logic [WIDTH-1:0] wr_data,
  output logic             rd_valid,
  input  logic             rd_ready,
  output logic [WIDTH-1:0] rd_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wptr;
  logic [AW-1:0]    rptr;
  logic [AW:0]      count;
  logic             push;
  logic             load;

  // ---------------------------------------------------------------
  // handshake
  // ---------------------------------------------------------------
  // the head register counts beyond DEPTH, so full means the array is full
  assign wr_ready = (count < (AW+1)'(DEPTH));
  assign push     = wr_valid & wr_ready & ~flush;
  assign load     = (count != '0) & (~rd_valid | rd_ready) & ~flush;

  // storage array, no reset needed on data
  always_ff @(posedge clk_sys) begin
    if (clk_en && push) begin
      mem[wptr] <= wr_data;
    end
  end

  // pointers and fill count
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wptr  <= '0;
      rptr  <= '0;
      count <= '0;
    end else if (clk_en) begin
      if (flush) begin
        wptr  <= '0;
        rptr  <= '0;
        count <= '0;
      end else begin
        if (push) begin
          wptr <= wptr + AW'(1);
        end
        if (load) begin
          rptr <= rptr + AW'(1);
        end
        count <= count + (AW+1)'(push) - (AW+1)'(load);
      end
    end
  end

  // registered head word; a pop with nothing behind it empties the head
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rd_valid <= 1'b0;
      rd_data  <= '0;
    end else if (clk_en) begin
      if (flush) begin
        rd_valid <= 1'b0;
      end else if (load) begin
        rd_valid <= 1'b1;
        rd_data  <= mem[rptr];
      end else if (rd_ready) begin
        rd_valid <= 1'b0;
      end
    end
  end

endmodule

// >>> core/parallel_readout_crc_port.sv
/*
 * Parallel 16-bit host port of a dual simultaneous-sampling converter:
 * mode latching at reset release, conversion readback through a FIFO,
 * command-word register access, self-test codes and the pair CRC.
 * Assumes the converter core sits on clk_sys and answers conv_start with
 * one conv_result_valid pulse carrying both results; host pins are async.
 */
`timescale 1ns/1ps
`include "prc_defs.svh"
module parallel_readout_crc_port #(
  parameter int FIFO_DEPTH = `PRC_FIFO_DEPTH
) (
  input  logic        clk_sys,
  input  logic        rst_n,
  input  logic        clk_en,
  input  logic [1:0]  operating_mode_select_pins,
  input  logic        interface_select_pin,
  input  logic        crc_enable_pin,
  input  logic        conversion_trigger,
  input  logic        cs_n,
  input  logic        rd_n,
  input  logic        wr_n,
  input  logic [15:0] data_bus_in,
  output logic [15:0] data_bus_out,
  output logic        data_bus_oe_n,
  output logic        busy,
  output logic        conv_start,
  input  logic        conv_result_valid,
  output logic        conv_result_ready,
  input  logic [15:0] conv_result_a,
  input  logic [15:0] conv_result_b,
  output logic [3:0]  channel_select_a,
  output logic [3:0]  channel_select_b,
  output logic        crc_active,
  output logic        software_mode,
  output logic        hw_crc_latched
);

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [`PRC_SYNC_W-1:0] pin_raw;
  logic [`PRC_SYNC_W-1:0] pin_meta;
  logic [`PRC_SYNC_W-1:0] pin_sync;
  logic [`PRC_SYNC_W-1:0] pin_prev;

  assign pin_raw = {conversion_trigger, cs_n, rd_n, wr_n, operating_mode_select_pins,
                    interface_select_pin, crc_enable_pin, data_bus_in};

  // two stages; strobes idle high so no false edge at release
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta <= `PRC_SYNC_RESET;
      pin_sync <= `PRC_SYNC_RESET;
      pin_prev <= `PRC_SYNC_RESET;
    end else if (clk_en) begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  logic        trig_rise;
  logic        cs_low;
  logic        cs_rise;
  logic        rd_low;
  logic        rd_fall;
  logic        wr_rise;
  logic [15:0] cmd;

  assign trig_rise = pin_sync[`PRC_PIN_TRIG] & ~pin_prev[`PRC_PIN_TRIG];
  assign cs_low    = ~pin_sync[`PRC_PIN_CS];
  assign cs_rise   = pin_sync[`PRC_PIN_CS] & ~pin_prev[`PRC_PIN_CS];
  assign rd_low    = ~pin_sync[`PRC_PIN_RD];
  assign rd_fall   = ~pin_sync[`PRC_PIN_RD] & pin_prev[`PRC_PIN_RD];
  assign wr_rise   = pin_sync[`PRC_PIN_WR] & ~pin_prev[`PRC_PIN_WR];
  // data must stay stable through the strobe's sync delay
  assign cmd       = pin_sync[15:0];

  // ---------------------------------------------------------------
  // mode latch at reset release
  // ---------------------------------------------------------------
  logic             latched;
  logic [1:0]       settle_cnt;
  prc_pkg::op_mode_t op_mode;
  logic             parallel_sel;
  logic             port_on;

  // straps are caught once the synchronisers hold real pin levels
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      latched        <= 1'b0;
      settle_cnt     <= 2'h0;
      op_mode        <= prc_pkg::MODE_HARDWARE;
      parallel_sel   <= 1'b0;
      hw_crc_latched <= 1'b0;
    end else if (clk_en && !latched) begin
      if (settle_cnt == `PRC_SETTLE_CYCLES) begin
        latched      <= 1'b1;
        op_mode      <= (pin_sync[`PRC_PIN_MODE_MSB:`PRC_PIN_MODE_LSB] == `PRC_MODE_SOFTWARE) ?
                        prc_pkg::MODE_SOFTWARE : prc_pkg::MODE_HARDWARE;
        parallel_sel <= (pin_sync[`PRC_PIN_IF] == `PRC_IF_PARALLEL);
        hw_crc_latched <= pin_sync[`PRC_PIN_CRC];
      end else begin
        settle_cnt <= settle_cnt + 2'h1;
      end
    end
  end

  assign software_mode = latched & (op_mode == prc_pkg::MODE_SOFTWARE);
  assign port_on       = latched & parallel_sel;

  // ---------------------------------------------------------------
  // register access
  // ---------------------------------------------------------------
  logic [8:0]  cfg_reg;
  logic [8:0]  chan_reg;
  logic [15:0] reg_out;
  logic        reg_pending;
  logic [15:0] reg_mux;
  logic [15:0] status_word;
  logic [7:0]  crc;
  logic        cmd_take;
  logic        rd_take;
  logic        self_test;
  logic [5:0]  cmd_addr;

  assign cmd_addr = cmd[`PRC_CMD_ADDR_MSB:`PRC_CMD_ADDR_LSB];
  // hardware mode leaves the port for conversion data only
  assign cmd_take = wr_rise & cs_low & port_on & software_mode;
  assign rd_take  = rd_fall & cs_low & port_on;

  // configuration and channel registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cfg_reg  <= `PRC_CFG_RESET;
      chan_reg <= `PRC_CHAN_RESET;
    end else if (clk_en && cmd_take && cmd[`PRC_CMD_WRITE_BIT]) begin
      case (cmd_addr)
        `PRC_ADDR_CONFIG:  cfg_reg  <= cmd[`PRC_CMD_DATA_MSB:0];
        `PRC_ADDR_CHANNEL: chan_reg <= cmd[`PRC_CMD_DATA_MSB:0];
        default: begin
        end
      endcase
    end
  end

  // read-back multiplexer; unmapped addresses read zero
  always_comb begin
    case (cmd_addr)
      `PRC_ADDR_CONFIG:  reg_mux = {7'h00, cfg_reg};
      `PRC_ADDR_CHANNEL: reg_mux = {7'h00, chan_reg};
      `PRC_ADDR_STATUS:  reg_mux = status_word;
      default:           reg_mux = 16'h0000;
    endcase
  end

  // read command parks the register in the output register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_out     <= 16'h0000;
      reg_pending <= 1'b0;
    end else if (clk_en) begin
      if (cmd_take && !cmd[`PRC_CMD_WRITE_BIT]) begin
        reg_out     <= reg_mux;
        reg_pending <= 1'b1;
      end else if (rd_take) begin
        reg_pending <= 1'b0;
      end
    end
  end

  // either bit couples CRC and status append; hardware parallel has neither
  assign crc_active       = software_mode &
                            (cfg_reg[`PRC_CFG_CRC_BIT] | cfg_reg[`PRC_CFG_STATUS_BIT]);
  assign channel_select_a = software_mode ? chan_reg[3:0] : 4'h0;
  assign channel_select_b = software_mode ? chan_reg[7:4] : 4'h0;
  assign self_test        = software_mode & (chan_reg[3:0] == `PRC_CH_SELFTEST);
  assign status_word      = {channel_select_a, channel_select_b, crc};

  // ---------------------------------------------------------------
  // CRC update
  // ---------------------------------------------------------------
  // duplicated terms are kept as the equations print them; they cancel
  function automatic logic [7:0] crc_step(input logic [15:0] d, input logic [7:0] c);
    logic [7:0] n;
    n[0] = d[14]^d[12]^d[8]^d[7]^d[6]^d[0]^c[0]^c[4]^c[6];
    n[1] = d[15]^d[14]^d[13]^d[12]^d[9]^d[6]^d[6]^d[1]^d[0]^c[1]^c[4]^c[5]^c[6]^c[7];
    n[2] = d[15]^d[13]^d[12]^d[10]^d[8]^d[6]^d[2]^d[1]^d[0]^c[0]^c[2]^c[4]^c[5]^c[7];
    n[3] = d[14]^d[13]^d[11]^d[9]^d[7]^d[3]^d[2]^d[1]^c[1]^c[3]^c[5]^c[6];
    n[4] = d[15]^d[14]^d[12]^d[10]^d[8]^d[4]^d[3]^d[2]^c[0]^c[2]^c[4]^c[6]^c[7];
    n[5] = d[15]^d[13]^d[11]^d[9]^d[5]^d[4]^d[3]^c[1]^c[6]^c[7];
    n[6] = d[14]^d[12]^d[10]^d[6]^d[5]^d[4]^c[2]^c[4]^c[6];
    n[7] = d[15]^d[13]^d[11]^d[7]^d[6]^d[5]^c[3]^c[3]^c[5]^c[7];
    return n;
  endfunction

  // ---------------------------------------------------------------
  // conversion control and FIFO fill
  // ---------------------------------------------------------------
  prc_pkg::conv_state_t state;
  logic [15:0] res_a;
  logic [15:0] res_b;
  logic [15:0] eff_a;
  logic [15:0] eff_b;
  logic        fifo_flush;
  logic        fifo_wr_valid;
  logic        fifo_wr_ready;
  logic [15:0] fifo_wr_data;
  logic        fifo_rd_valid;
  logic        fifo_rd_ready;
  logic [15:0] fifo_rd_data;

  assign eff_a = self_test ? `PRC_SELFTEST_A : conv_result_a;
  assign eff_b = self_test ? `PRC_SELFTEST_B : conv_result_b;
  assign conv_result_ready = (state == prc_pkg::CONV_WAIT);
  // capturing a new pair drops stale words so the next read is A
  assign fifo_flush = conv_result_ready & conv_result_valid;

  // a trigger while busy is ignored; the chain restarts with each pair
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state      <= prc_pkg::CONV_IDLE;
      busy       <= 1'b0;
      conv_start <= 1'b0;
      res_a      <= 16'h0000;
      res_b      <= 16'h0000;
      crc        <= `PRC_CRC_INIT;
    end else if (clk_en) begin
      conv_start <= 1'b0;
      case (state)
        prc_pkg::CONV_IDLE: begin
          if (trig_rise && port_on) begin
            conv_start <= 1'b1;
            busy       <= 1'b1;
            state      <= prc_pkg::CONV_WAIT;
          end
        end
        prc_pkg::CONV_WAIT: begin
          if (conv_result_valid) begin
            res_a <= eff_a;
            res_b <= eff_b;
            crc   <= crc_step(eff_b, crc_step(eff_a, `PRC_CRC_INIT));
            state <= prc_pkg::CONV_PUSH_A;
          end
        end
        prc_pkg::CONV_PUSH_A: begin
          if (fifo_wr_ready) begin
            state <= prc_pkg::CONV_PUSH_B;
          end
        end
        prc_pkg::CONV_PUSH_B: begin
          if (fifo_wr_ready) begin
            if (crc_active) begin
              state <= prc_pkg::CONV_PUSH_STATUS;
            end else begin
              state <= prc_pkg::CONV_IDLE;
              busy  <= 1'b0;
            end
          end
        end
        prc_pkg::CONV_PUSH_STATUS: begin
          if (fifo_wr_ready) begin
            state <= prc_pkg::CONV_IDLE;
            busy  <= 1'b0;
          end
        end
        default: begin
          state <= prc_pkg::CONV_IDLE;
          busy  <= 1'b0;
        end
      endcase
    end
  end

  // words leave in order A, B, then status when CRC is on
  always_comb begin
    fifo_wr_valid = 1'b1;
    case (state)
      prc_pkg::CONV_PUSH_A:      fifo_wr_data = res_a;
      prc_pkg::CONV_PUSH_B:      fifo_wr_data = res_b;
      prc_pkg::CONV_PUSH_STATUS: fifo_wr_data = status_word;
      default: begin
        fifo_wr_valid = 1'b0;
        fifo_wr_data  = 16'h0000;
      end
    endcase
  end

  sync_word_fifo #(
    .WIDTH (16),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .clk_en   (clk_en),
    .flush    (fifo_flush),
    .wr_valid (fifo_wr_valid),
    .wr_ready (fifo_wr_ready),
    .wr_data  (fifo_wr_data),
    .rd_valid (fifo_rd_valid),
    .rd_ready (fifo_rd_ready),
    .rd_data  (fifo_rd_data)
  );

  // ---------------------------------------------------------------
  // readback and bus drive
  // ---------------------------------------------------------------
  // a pending register answer goes before conversion words
  assign fifo_rd_ready = rd_take & ~reg_pending & ~fifo_flush;

  // each read falling edge presents the next word while one is queued; an empty FIFO leaves the last word
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      data_bus_out <= 16'h0000;
    end else if (clk_en && rd_take) begin
      if (reg_pending) begin
        data_bus_out <= reg_out;
      end else if (fifo_rd_valid && !fifo_flush) begin
        data_bus_out <= fifo_rd_data;
      end
    end
  end

  // drive only while select and read are low; release floats the bus
  assign data_bus_oe_n = ~(port_on & cs_low & rd_low);

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_bus_drive_gate: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !data_bus_oe_n |-> (!pin_sync[`PRC_PIN_CS] && !pin_sync[`PRC_PIN_RD] && parallel_sel))
    else $error("data bus driven outside select and read");

  a_cs_release_float: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cs_rise |-> data_bus_oe_n)
    else $error("bus still driven after select rise");

  a_trigger_busy: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (clk_en && trig_rise && port_on && state == prc_pkg::CONV_IDLE) |=> (busy && conv_start))
    else $error("trigger did not raise busy");

  a_readback_word: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (clk_en && fifo_rd_ready && fifo_rd_valid) |=> (data_bus_out == $past(fifo_rd_data)))
    else $error("read did not present head word");

  a_selftest_codes: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (clk_en && fifo_flush && self_test) |=> (res_a == `PRC_SELFTEST_A && res_b == `PRC_SELFTEST_B))
    else $error("self-test codes not forced");

  a_hw_regs_frozen: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (latched && !software_mode) |=> ($stable(cfg_reg) && $stable(chan_reg) && !reg_pending))
    else $error("register changed in hardware mode");

  a_hw_no_crc: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !software_mode |-> (!crc_active && !self_test))
    else $error("crc or self-test active in hardware mode");

  a_status_append: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (clk_en && state == prc_pkg::CONV_PUSH_B && fifo_wr_ready && crc_active)
      |=> (fifo_wr_valid && fifo_wr_data[7:0] == crc))
    else $error("status word not appended");

  a_flush_rewind: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (clk_en && fifo_flush) |=> (!fifo_rd_valid && state == prc_pkg::CONV_PUSH_A))
    else $error("new conversion did not rewind readback");

endmodule

// >>> sim/host_model.sv
/*
 * Host controller model on the 16-bit parallel port: command writes and
 * word reads, plus the resolved level of the shared data bus.
 * Assumes the bench calls its tasks at falling edges of clk_sys.
 */
`timescale 1ns/1ps
module host_model (
  input  wire logic        clk_sys,
  input  wire logic [15:0] data_bus_out,
  input  wire logic        data_bus_oe_n,
  output logic             cs_n,
  output logic             rd_n,
  output logic             wr_n,
  output logic [15:0]      data_bus_in
);
  logic [15:0] drv;
  logic        own;

  // -------------------------------------------------------------
  // bus level
  // -------------------------------------------------------------
  initial begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    own = 1'b0;
    drv = 16'h0000;
    data_bus_in = 16'hFFFF;
  end
  // no pull on the bus: an undriven bus toggles so stale data never looks valid
  always @(negedge clk_sys) data_bus_in <= !data_bus_oe_n ? data_bus_out : own ? drv : ~data_bus_in;

  // -------------------------------------------------------------
  // bus cycles
  // -------------------------------------------------------------
  task automatic hold(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  // strobes are synchronised, so every level lasts at least three cycles
  task automatic wr(input logic [15:0] w);
    drv = w;
    own = 1'b1;
    cs_n = 1'b0;
    hold(1);
    wr_n = 1'b0;
    hold(4);
    wr_n = 1'b1;
    hold(4);
    own = 1'b0;
    cs_n = 1'b1;
    hold(3);
  endtask

  task automatic rd(output logic [15:0] v);
    cs_n = 1'b0;
    hold(1);
    rd_n = 1'b0;
    hold(5);
    v = data_bus_oe_n ? 16'hXXXX : data_bus_out;
    rd_n = 1'b1;
    hold(3);
    cs_n = 1'b1;
    hold(3);
  endtask
endmodule

// >>> sim/parallel_readout_crc_port_bench.sv
/*
 * Self-checking bench of the parallel readout port: one task per scenario.
 * Assumes host_model and the design files are compiled first.
 */
`timescale 1ns/1ps
`include "prc_defs.svh"
module parallel_readout_crc_port_bench;
  logic        clk_sys = 1'b0;
  logic        rst_n   = 1'b0;
  logic [1:0]  mode    = 2'h0;
  logic        if_pin  = 1'b0;
  logic        crc_pin = 1'b0;
  logic        trig    = 1'b0;
  logic        en      = 1'b1;
  logic [15:0] ra      = 16'h0000;
  logic [15:0] rb      = 16'h0000;
  logic [2:0]  cnt     = 3'h0;
  logic [15:0] dout, din, v;
  logic [3:0]  sa, sb;
  logic        oe_n, busy, start, ready, valid, cs_n, rd_n, wr_n, swm, crca, hwcrc;
  int          n_mismatch = 0;
  int          check_count = 0;

  // ------------------------------------------------
  // clock and converter stand-in
  // ------------------------------------------------
  always #10 clk_sys = ~clk_sys;
  // result arrives four cycles after the start pulse
  always @(posedge clk_sys) cnt <= start ? 3'h4 : (cnt != 3'h0) ? cnt - 3'h1 : cnt;
  assign valid = (cnt == 3'h1);

  parallel_readout_crc_port #(.FIFO_DEPTH(16)) i_dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .clk_en(en), .operating_mode_select_pins(mode),
    .interface_select_pin(if_pin), .crc_enable_pin(crc_pin), .conversion_trigger(trig),
    .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .data_bus_in(din), .data_bus_out(dout),
    .data_bus_oe_n(oe_n), .busy(busy), .conv_start(start), .conv_result_valid(valid),
    .conv_result_ready(ready), .conv_result_a(ra), .conv_result_b(rb),
    .channel_select_a(sa), .channel_select_b(sb), .crc_active(crca),
    .software_mode(swm), .hw_crc_latched(hwcrc));

  host_model i_host (
    .clk_sys(clk_sys), .data_bus_out(dout), .data_bus_oe_n(oe_n),
    .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .data_bus_in(din));

  // ------------------------------------------------
  // helpers
  // ------------------------------------------------
  function automatic logic [7:0] crc_out(input logic [15:0] d, input logic [7:0] c);
    logic [7:0] o;
    o[0] = d[14]^d[12]^d[8]^d[7]^d[6]^d[0]^c[0]^c[4]^c[6];
    o[1] = d[15]^d[14]^d[13]^d[12]^d[9]^d[6]^d[6]^d[1]^d[0]^c[1]^c[4]^c[5]^c[6]^c[7];
    o[2] = d[15]^d[13]^d[12]^d[10]^d[8]^d[6]^d[2]^d[1]^d[0]^c[0]^c[2]^c[4]^c[5]^c[7];
    o[3] = d[14]^d[13]^d[11]^d[9]^d[7]^d[3]^d[2]^d[1]^c[1]^c[3]^c[5]^c[6];
    o[4] = d[15]^d[14]^d[12]^d[10]^d[8]^d[4]^d[3]^d[2]^c[0]^c[2]^c[4]^c[6]^c[7];
    o[5] = d[15]^d[13]^d[11]^d[9]^d[5]^d[4]^d[3]^c[1]^c[6]^c[7];
    o[6] = d[14]^d[12]^d[10]^d[6]^d[5]^d[4]^c[2]^c[4]^c[6];
    o[7] = d[15]^d[13]^d[11]^d[7]^d[6]^d[5]^c[3]^c[3]^c[5]^c[7];
    return o;
  endfunction

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test;
    $display("comparisons %0d, mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // a hang on busy ends the run at once
  task automatic wait_busy(input logic lvl);
    int n;
    n = 0;
    while (busy !== lvl && n < 50) begin
      @(negedge clk_sys);
      n++;
    end
    if (n == 50) begin
      n_mismatch++;
      stop_test();
    end
  endtask

  // straps stay put well past the capture point
  task automatic restart(input logic [1:0] m, input logic ifp, input logic cp);
    @(negedge clk_sys);
    rst_n = 1'b0;
    mode = m;
    if_pin = ifp;
    crc_pin = cp;
    repeat (6) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (8) @(negedge clk_sys);
  endtask

  task automatic convert(input logic [15:0] a, input logic [15:0] b);
    ra = a;
    rb = b;
    trig = 1'b1;
    wait_busy(1'b1);
    chk({15'h0, ready}, 16'h0001);
    trig = 1'b0;
    wait_busy(1'b0);
  endtask

  task automatic rd_chk(input logic [15:0] e);
    i_host.rd(v);
    chk(v, e);
  endtask

  task automatic reg_wr(input logic [5:0] a, input logic [8:0] d);
    i_host.wr({1'b1, a, d});
  endtask

  // ------------------------------------------------
  // scenarios
  // ------------------------------------------------
  task automatic t_readback;
    restart(2'h0, 1'b0, 1'b0);
    chk({15'h0, swm}, 16'h0001);
    chk({8'h00, sa, sb}, 16'h0000);
    i_host.rd_n = 1'b0;
    repeat (5) @(negedge clk_sys);
    chk({15'h0, oe_n}, 16'h0001);
    i_host.rd_n = 1'b1;
    convert(16'h1234, 16'hABCD);
    rd_chk(16'h1234);
    rd_chk(16'hABCD);
    chk({15'h0, oe_n}, 16'h0001);
    rd_chk(16'hABCD);
    convert(16'h0F0F, 16'hF0F0);
    i_host.rd(v);
    convert(16'h7001, 16'h8002);
    rd_chk(16'h7001);
  endtask

  task automatic t_registers;
    reg_wr(`PRC_ADDR_CONFIG, 9'h001);
    chk({15'h0, crca}, 16'h0001);
    i_host.wr({1'b0, `PRC_ADDR_CONFIG, 9'h000});
    rd_chk(16'h0001);
    reg_wr(`PRC_ADDR_CONFIG, 9'h002);
    chk({15'h0, crca}, 16'h0001);
    reg_wr(`PRC_ADDR_CONFIG, 9'h000);
    chk({15'h0, crca}, 16'h0000);
    i_host.wr({1'b0, 6'h3F, 9'h000});
    rd_chk(16'h0000);
    reg_wr(`PRC_ADDR_CONFIG, 9'h001);
    convert(16'h1234, 16'hABCD);
    rd_chk(16'h1234);
    rd_chk(16'hABCD);
    rd_chk({8'h00, crc_out(16'hABCD, crc_out(16'h1234, 8'h00))});
  endtask

  // self-test words also feed the checksum
  task automatic t_channels;
    reg_wr(`PRC_ADDR_CHANNEL, 9'h098);
    chk({8'h00, sa, sb}, 16'h0089);
    reg_wr(`PRC_ADDR_CHANNEL, 9'h00B);
    convert(16'h1111, 16'h2222);
    rd_chk(16'hAAAA);
    rd_chk(16'h5555);
    rd_chk({8'hB0, crc_out(16'h5555, crc_out(16'hAAAA, 8'h00))});
  endtask

  // a low clock enable freezes the synchronisers, so a trigger then is never seen
  task automatic t_freeze;
    en = 1'b0;
    trig = 1'b1;
    repeat (6) @(negedge clk_sys);
    chk({15'h0, busy}, 16'h0000);
    trig = 1'b0;
    en = 1'b1;
    repeat (4) @(negedge clk_sys);
    chk({15'h0, busy}, 16'h0000);
  endtask

  task automatic t_hardware;
    for (int m = 3; m > 0; m--) begin
      restart(m[1:0], 1'b0, 1'b1);
      chk({13'h0, swm, hwcrc, crca}, 16'h0002);
    end
    reg_wr(`PRC_ADDR_CHANNEL, 9'h00B);
    chk({8'h00, sa, sb}, 16'h0000);
    convert(16'h1357, 16'h2468);
    rd_chk(16'h1357);
    rd_chk(16'h2468);
    rd_chk(16'h2468);
    restart(2'h0, 1'b1, 1'b0);
    i_host.cs_n = 1'b0;
    i_host.rd_n = 1'b0;
    repeat (5) @(negedge clk_sys);
    chk({15'h0, oe_n}, 16'h0001);
    i_host.rd_n = 1'b1;
    i_host.cs_n = 1'b1;
  endtask

  initial begin
    t_readback();
    t_registers();
    t_channels();
    t_freeze();
    t_hardware();
    stop_test();
  end
endmodule
